/* verilog/fbc_regs.svh */
// Register offsets, field positions, the key value, the mask range and timing counts.
`ifndef FBC_REGS_SVH
`define FBC_REGS_SVH
`define FBC_KEY_OFF 12'h000
`define FBC_MODE_OFF 12'h004
`define FBC_STATUS_OFF 12'h01C
`define FBC_IRQ_MASK_OFF 12'h018
`define FBC_DATA_OFF 12'h020
`define FBC_DATA_BASE 12'h020
`define FBC_DATA_END 12'h0A0
`define FBC_KEY_VALUE 8'hFB
`define FBC_MASK_BIT 0
`define FBC_PROGRAM_COMPLETE_FLAG_BIT 0
`define FBC_PROGRAM_FAILED_FLAG_BIT 1
`define FBC_PROG_CYCLES 8'h10
`define FBC_MASK_FIRST 5'h14
`define FBC_MASK_LAST 5'h17
`endif

/* verilog/fbc_pkg.sv */
// Types shared by the fuse box controller.
package fbc_pkg;
  typedef enum logic [2:0] {
    FBC_IDLE = 3'b001,
    FBC_BURN = 3'b010,
    FBC_READ = 3'b100
  } fbc_state_t;
endpackage

/* verilog/fbc_fuse_box_controller.sv */
// Fuse box controller with key unlock, programming, readback and masking.
`timescale 1ns/100ps
`include "fbc_regs.svh"

module fbc_fuse_box_controller #(
  parameter int NUM_WORDS = 32,
  parameter logic [7:0] PROG_CYCLES = `FBC_PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic mask_active,
  input wire logic fuse_burn_fault
);
  import fbc_pkg::*;

  fbc_state_t state;
  fbc_state_t next_state;
  logic [31:0] fuses [NUM_WORDS];
  logic [31:0] data_reg [NUM_WORDS];
  logic [31:0] burn_word;
  logic [31:0] next_burn_word;
  logic [4:0] burn_idx;
  logic [4:0] next_burn_idx;
  logic [7:0] count;
  logic [7:0] next_count;
  logic unlocked;
  logic next_unlocked;
  logic masked;
  logic next_masked;
  logic [1:0] status;
  logic [1:0] next_status;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_mask;
  logic fail_seen;
  logic next_fail_seen;
  logic fault_s1;
  logic fault_s2;
  logic [31:0] next_prdata;
  logic rd_setup;
  logic mapped;
  logic key_hit;
  logic mode_hit;
  logic status_hit;
  logic irq_mask_hit;
  logic masked_word;
  logic wr;
  logic rd;
  logic data_hit;
  logic [4:0] widx;
  logic [11:0] doff;
  logic done_ev;
  logic fail_ev;

  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign doff = paddr - `FBC_DATA_BASE;
  assign widx = doff[6:2];
  assign data_hit = (paddr >= `FBC_DATA_BASE) && (paddr < `FBC_DATA_END)
    && (paddr[1:0] == 2'b00) && (32'(widx) < NUM_WORDS);
  assign irq = |(status & irq_mask);
  assign mask_active = masked;
  assign done_ev = (state == FBC_READ);
  assign fail_ev = done_ev & fail_seen;
  // An access outside the map answers with an error; a write there still cancels the unlock.
  assign mapped = key_hit | mode_hit | status_hit | irq_mask_hit
    | data_hit;
  assign masked_word = masked && (widx >= `FBC_MASK_FIRST)
    && (widx <= `FBC_MASK_LAST);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~mapped;

  // Decodes the single registers by offset; data words match by range.
  always_comb begin
    key_hit = 1'b0;
    mode_hit = 1'b0;
    status_hit = 1'b0;
    irq_mask_hit = 1'b0;
    case (paddr)
      `FBC_KEY_OFF: begin
        key_hit = 1'b1;
      end
      `FBC_MODE_OFF: begin
        mode_hit = 1'b1;
      end
      `FBC_STATUS_OFF: begin
        status_hit = 1'b1;
      end
      `FBC_IRQ_MASK_OFF: begin
        irq_mask_hit = 1'b1;
      end
      default: begin
        key_hit = 1'b0;
      end
    endcase
  end

  // The fault pin is asynchronous, so it passes two flip-flops first.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_s1 <= 1'b0;
      fault_s2 <= 1'b0;
    end else begin
      fault_s1 <= fuse_burn_fault;
      fault_s2 <= fault_s1;
    end
  end

  // Any write between the key and the data word, except the key value written again, cancels the unlock.
  always_comb begin
    next_state = state;
    next_burn_word = burn_word;
    next_burn_idx = burn_idx;
    next_count = count;
    next_unlocked = unlocked;
    next_fail_seen = fail_seen;
    case (state)
      FBC_IDLE: begin
        if (wr && paddr == `FBC_KEY_OFF) begin
          next_unlocked = (pwdata[7:0] == `FBC_KEY_VALUE);
        end else if (wr && data_hit) begin
          if (unlocked) begin
            next_state = FBC_BURN;
            next_burn_word = pwdata;
            next_burn_idx = widx;
            next_count = PROG_CYCLES;
            next_fail_seen = 1'b0;
          end
          next_unlocked = 1'b0;
        end else if (wr) begin
          next_unlocked = 1'b0;
        end
      end
      FBC_BURN: begin
        if (fault_s2) begin
          next_fail_seen = 1'b1;
        end
        if (count == 8'h01) begin
          next_state = FBC_READ;
        end
        next_count = count - 8'h01;
      end
      FBC_READ: begin
        next_state = FBC_IDLE;
      end
      default: begin
        next_state = FBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= FBC_IDLE;
      burn_word <= 32'h0;
      burn_idx <= 5'h0;
      count <= 8'h0;
      unlocked <= 1'b0;
      fail_seen <= 1'b0;
    end else begin
      state <= next_state;
      burn_word <= next_burn_word;
      burn_idx <= next_burn_idx;
      count <= next_count;
      unlocked <= next_unlocked;
      fail_seen <= next_fail_seen;
    end
  end

  // A failed burn leaves the fuses as they were and still reads back.
  generate
    for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
      logic [31:0] next_fuse;
      logic [31:0] next_data;
      always_comb begin
        next_fuse = fuses[i];
        next_data = data_reg[i];
        if (state == FBC_BURN && count == 8'h01 && !fail_seen
            && !fault_s2 && 32'(burn_idx) == i) begin
          next_fuse = fuses[i] | burn_word;
        end
        if (done_ev && 32'(burn_idx) == i) begin
          next_data = fuses[i];
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          fuses[i] <= 32'h0;
          data_reg[i] <= 32'h0;
        end else begin
          fuses[i] <= next_fuse;
          data_reg[i] <= next_data;
        end
      end
    end
  endgenerate

  // Masking only ever sets; the asynchronous reset is the one way back.
  always_comb begin
    next_masked = masked;
    if (wr && mode_hit && pwdata[`FBC_MASK_BIT]) begin
      next_masked = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      masked <= 1'b0;
    end else begin
      masked <= next_masked;
    end
  end

  // An event in the cycle of a clear still wins, so software never
  // loses a completion that lands during its clear.
  always_comb begin
    next_status = status;
    if (wr && status_hit) begin
      next_status = status & ~pwdata[1:0];
    end
    if (done_ev) begin
      next_status[`FBC_PROGRAM_COMPLETE_FLAG_BIT] = 1'b1;
    end
    if (fail_ev) begin
      next_status[`FBC_PROGRAM_FAILED_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= 2'h0;
    end else begin
      status <= next_status;
    end
  end

  // The interrupt mask has the status layout; irq is a level.
  always_comb begin
    next_irq_mask = irq_mask;
    if (wr && irq_mask_hit) begin
      next_irq_mask = pwdata[1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 2'h0;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // Read data is captured in the setup phase, so it stands in a
  // flip-flop through the whole access phase with no wait state.
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      if (mode_hit) begin
        next_prdata = {31'h0, masked};
      end else if (status_hit) begin
        next_prdata = {30'h0, status};
      end else if (irq_mask_hit) begin
        next_prdata = {30'h0, irq_mask};
      end else if (data_hit && masked_word) begin
        next_prdata = 32'h0;
      end else if (data_hit) begin
        next_prdata = data_reg[widx];
      end else begin
        next_prdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule

/* tb/fbc_fuse_box_controller_properties.sv */
// Port checker for the fuse box controller.
`timescale 1ns/100ps
module fbc_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic mask_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire mode_set = acc && pwrite && paddr == 12'h004 && pwdata[0];
  wire rd_mask = acc && !pwrite && paddr >= 12'h070 && paddr <= 12'h07C;
  property p_set; mode_set |-> ##[1:2] mask_active; endproperty
  a_set: assert property (p_set) else $error("mask not set");
  property p_keep; mask_active |=> mask_active; endproperty
  a_keep: assert property (p_keep) else $error("mask lost");
  property p_cause;
    $rose(mask_active) |-> $past(mode_set) || $past(mode_set, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("mask rose");
  property p_zero; mask_active && rd_mask |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("masked data");
  property p_data; acc && paddr[11:5] == 7'h01 |-> !pslverr; endproperty
  a_data: assert property (p_data) else $error("data error");
  property p_stat; acc && paddr == 12'h01C |-> !pslverr; endproperty
  a_stat: assert property (p_stat) else $error("status error");
  property p_key; acc && paddr == 12'h000 |-> !pslverr; endproperty
  a_key: assert property (p_key) else $error("key error");
  property p_bad; acc && paddr >= 12'h0A0 |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("no error");
endmodule
bind fbc_fuse_box_controller fbc_checker fbc_checker_i (
  .clock(clock),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pslverr(pslverr),
  .mask_active(mask_active)
);

/* tb/fbc_fuse_box_controller_test.sv */
// Self-checking bench for the fuse box controller.
`timescale 1ns/100ps
module fbc_fuse_box_controller_test;
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } fbc_row_t;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic fuse_burn_fault = 0, pready, pslverr, irq, mask_active, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int failures = 0, checks_done = 0;
  fbc_row_t rows [7] = '{'{1'b0, 12'h01C, 32'h0, 32'h0},
    '{1'b1, 12'h020, 32'hFFFFFFFF, 32'h0}, '{1'b0, 12'h020, 32'h0, 32'h0},
    '{1'b1, 12'h000, 32'hFB, 32'h0}, '{1'b1, 12'h004, 32'h0, 32'h0},
    '{1'b1, 12'h030, 32'hFFFF, 32'h0}, '{1'b0, 12'h030, 32'h0, 32'h0}};
  fbc_fuse_box_controller #(
    .PROG_CYCLES(8'h02)
  ) fbc_fuse_box_controller_i (
    .clock(clock),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .mask_active(mask_active),
    .fuse_burn_fault(fuse_burn_fault)
  );
  always #5 clock = ~clock;
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic prog(logic [11:0] a, logic [31:0] d, logic f, logic ie,
      logic [31:0] x);
    int n;
    apb(1'b1, 12'h000, 32'hFB);
    apb(1'b1, a, d);
    n = 0;
    do begin
      apb(1'b0, 12'h01C, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 30);
    chk("status", rd, {30'h0, f, 1'b1});
    chk("irq", {31'h0, irq}, {31'h0, ie});
    apb(1'b1, 12'h01C, 32'h3);
    @(negedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b0, a, 32'h0);
    chk("data", rd, x);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("row", rd, rows[i].e);
    end
    apb(1'b1, 12'h018, 32'h1);
    prog(12'h020, 32'hA5, 1'b0, 1'b1, 32'hA5);
    prog(12'h020, 32'hF00, 1'b0, 1'b1, 32'hFA5);
    prog(12'h09C, 32'hFFFFFFFF, 1'b0, 1'b1, 32'hFFFFFFFF);
    apb(1'b1, 12'h018, 32'h0);
    fuse_burn_fault <= 1;
    prog(12'h028, 32'h3, 1'b1, 1'b0, 32'h0);
    fuse_burn_fault <= 0;
    prog(12'h070, 32'h12345678, 1'b0, 1'b0, 32'h12345678);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h070, 32'h0);
    chk("masked", rd, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    chk("mask", {31'h0, mask_active}, 32'h1);
    prog(12'h074, 32'hF, 1'b0, 1'b0, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("err", {31'h0, er}, 32'h1);
    rst_n <= 0;
    @(posedge clock);
    rst_n <= 1;
    chk("mask", {31'h0, mask_active}, 32'h0);
    complete_run();
  end
endmodule
